// file: verilog/cdm_pkg.sv
// constants of the lane clock-recovery and signal-conditioning management block
//
// Behaviour
// - byte 5 bits 7..4 latch transmit recovery loss-of-lock, lanes 4..1
// - byte 5 bits 3..0 latch receive recovery loss-of-lock, lanes 4..1
// - byte 98 bits 7..4 enable transmit recovery lanes 4..1, zero bypasses
// - byte 98 bits 3..0 enable receive recovery lanes 4..1, zero turns off
// - amplitude codes 0000b..0011b select four ranges, higher codes reserved
// - input equalization codes 0000b..1010b give 0..10 dB, rest reserved
// - output emphasis codes 0000b..0111b give 0..7 dB, top bit reserved
// - device fully functional at most 2000 ms after reset release
// - reset pin held low at least 2 us is taken as a reset
// - management bus answers no later than 2000 ms after power-on
// - fully functional means data-not-ready cleared and interrupt asserted for it
// - reading a latched flag clears it and releases the interrupt within 500 us
package cdm_pkg;

  // clock rate
  localparam int CLK_MHZ = 250;

  // timing figures as printed
  localparam int RESET_PULSE_NS = 2000;
  localparam int INIT_MS        = 2000;
  localparam int SERIAL_MS      = 2000;

  // least time rounds up, longest time rounds down
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_CYC        = INIT_MS * CLK_MHZ * 1000;
  localparam int SERIAL_CYC      = SERIAL_MS * CLK_MHZ * 1000;

  // byte offsets, lower memory
  localparam logic [7:0] OFS_STATUS   = 8'h02;
  localparam logic [7:0] OFS_LOL      = 8'h05;
  localparam logic [7:0] OFS_CDR_EN   = 8'h62;
  localparam logic [7:0] OFS_PAGE_SEL = 8'h7f;

  // byte offsets, upper memory page 3
  localparam logic [7:0] PAGE_COND   = 8'h03;
  localparam logic [7:0] OFS_TX_EQ   = 8'hea;
  localparam logic [7:0] OFS_RX_EMPH = 8'hec;
  localparam logic [7:0] OFS_RX_AMP  = 8'hee;

  // field positions
  localparam int TX_FIELD_LSB  = 4;
  localparam int RX_FIELD_LSB  = 0;
  localparam int NOT_READY_BIT = 0;

  // largest legal codes
  localparam logic [3:0] AMP_CODE_MAX  = 4'h3;
  localparam logic [3:0] EQ_CODE_MAX   = 4'ha;
  localparam logic [3:0] EMPH_CODE_MAX = 4'h7;

  // reset values
  localparam logic [7:0]  RST_CDR_EN = 8'hff;
  localparam logic [15:0] RST_CODES  = 16'h0000;
  localparam logic [7:0]  RST_PAGE   = 8'h00;

  // default serial slave address, arbitrary
  localparam logic [6:0] DEF_DEV_ADDR = 7'h50;

  // serial slave states
  typedef enum logic [6:0] {
    CDM_IDLE   = 7'b0000001,
    CDM_ADDR   = 7'b0000010,
    CDM_ACK_AD = 7'b0000100,
    CDM_WRITE  = 7'b0001000,
    CDM_ACK_WR = 7'b0010000,
    CDM_READ   = 7'b0100000,
    CDM_ACK_RD = 7'b1000000
  } cdm_state_t;

endpackage

// file: verilog/cdm_reset_init.sv
// reset pin qualifier and initialisation timer
`timescale 1ns/1ps
`default_nettype none

module cdm_reset_init #(
  parameter int PULSE_CYCLES  = cdm_pkg::RESET_PULSE_CYC,
  parameter int SERIAL_CYCLES = cdm_pkg::SERIAL_CYC,
  parameter int INIT_CYCLES   = cdm_pkg::INIT_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic pin_n_i,
  output logic      soft_rst_o,
  output logic      bus_ready_o,
  output logic      data_ready_o
);

  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int CW = $clog2(INIT_CYCLES + 1);

  // refuse counts the logic cannot serve
  if (PULSE_CYCLES < 1 || SERIAL_CYCLES < 1 || INIT_CYCLES < SERIAL_CYCLES) begin : g_bad
    $error("cdm_reset_init: bad cycle counts");
  end

  logic          pin_meta;
  logic          pin_sync;
  logic [PW-1:0] low_cnt;
  logic [CW-1:0] init_cnt;

  // pin synchroniser
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= pin_n_i;
      pin_sync <= pin_meta;
    end
  end

  // low-time counter, saturating at the least pulse width
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || pin_sync) begin
      low_cnt <= '0;
    end else if (low_cnt != PW'(PULSE_CYCLES)) begin
      low_cnt <= low_cnt + PW'(1);
    end
  end

  // reset held while a long enough low level stays on the pin
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      soft_rst_o <= 1'b0;
    end else begin
      soft_rst_o <= !pin_sync && (low_cnt == PW'(PULSE_CYCLES));
    end
  end

  // initialisation timer restarts on every reset
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || soft_rst_o) begin
      init_cnt     <= '0;
      bus_ready_o  <= 1'b0;
      data_ready_o <= 1'b0;
    end else begin
      if (init_cnt != CW'(INIT_CYCLES)) begin
        init_cnt <= init_cnt + CW'(1);
      end
      bus_ready_o  <= (init_cnt >= CW'(SERIAL_CYCLES));
      data_ready_o <= (init_cnt == CW'(INIT_CYCLES));
    end
  end

endmodule

`default_nettype wire

// file: verilog/cdm_mgmt.sv
// management registers of the lane clock-recovery and signal-conditioning block
`timescale 1ns/1ps
`default_nettype none

module cdm_mgmt #(
  parameter logic [6:0] DEV_ADDR      = cdm_pkg::DEF_DEV_ADDR,
  parameter int         LANES         = 4,
  parameter int         PULSE_CYCLES  = cdm_pkg::RESET_PULSE_CYC,
  parameter int         SERIAL_CYCLES = cdm_pkg::SERIAL_CYC,
  parameter int         INIT_CYCLES   = cdm_pkg::INIT_CYC
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              reset_pin_active_low_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic [LANES-1:0]  tx_lock_lost_i,
  input  wire logic [LANES-1:0]  rx_lock_lost_i,
  output logic [LANES-1:0]       tx_recovery_enable_o,
  output logic [LANES-1:0]       rx_recovery_enable_o,
  output logic [4*LANES-1:0]     tx_eq_code_o,
  output logic [4*LANES-1:0]     rx_emph_code_o,
  output logic [4*LANES-1:0]     rx_amp_code_o,
  output logic                   data_not_ready_o,
  output logic                   interrupt_out_active_low_o
);

  // the byte map has room for exactly four lanes
  if (LANES != 4) begin : g_bad
    $error("cdm_mgmt: LANES must be 4");
  end

  logic                 soft_rst;
  logic                 bus_ready;
  logic                 data_ready;
  logic                 data_ready_q;
  logic                 rst;
  logic [1:0]           scl_meta;
  logic [1:0]           sda_meta;
  logic [1:0]           scl_s;
  logic [1:0]           sda_s;
  logic [LANES-1:0]     tx_ll_meta;
  logic [LANES-1:0]     rx_ll_meta;
  logic [LANES-1:0]     tx_ll_sync;
  logic [LANES-1:0]     rx_ll_sync;
  logic [LANES-1:0]     tx_lol;
  logic [LANES-1:0]     rx_lol;
  logic                 ready_evt;
  logic [7:0]           page;
  cdm_pkg::cdm_state_t  state;
  logic [3:0]           bit_cnt;
  logic [7:0]           shreg;
  logic                 rw;
  logic                 first;
  logic [7:0]           ptr;
  logic [7:0]           rd_byte;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_c;
  logic                 stop_c;
  logic                 load_rd;
  logic                 wr_en;
  logic                 clr_lol;
  logic                 clr_ready;
  logic                 upper3;

  cdm_reset_init #(
    .PULSE_CYCLES  (PULSE_CYCLES),
    .SERIAL_CYCLES (SERIAL_CYCLES),
    .INIT_CYCLES   (INIT_CYCLES)
  ) u_init (
    .sys_clk_i    (sys_clk_i),
    .reset_n_i    (reset_n_i),
    .pin_n_i      (reset_pin_active_low_i),
    .soft_rst_o   (soft_rst),
    .bus_ready_o  (bus_ready),
    .data_ready_o (data_ready)
  );

  // a qualified pin reset clears the same state as the system reset, except the synchronisers
  assign rst = !reset_n_i || soft_rst;

  // two-stage synchronisers for bus pins and lock-loss inputs
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      scl_meta   <= 2'h3;
      sda_meta   <= 2'h3;
      tx_ll_meta <= '0;
      rx_ll_meta <= '0;
      tx_ll_sync <= '0;
      rx_ll_sync <= '0;
    end else begin
      scl_meta   <= {scl_meta[0], scl_i};
      sda_meta   <= {sda_meta[0], sda_i};
      tx_ll_meta <= tx_lock_lost_i;
      rx_ll_meta <= rx_lock_lost_i;
      tx_ll_sync <= tx_ll_meta;
      rx_ll_sync <= rx_ll_meta;
    end
  end

  // delayed copies of the synchronised bus pins for edge detection
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
    end else begin
      scl_s <= {scl_s[0], scl_meta[1]};
      sda_s <= {sda_s[0], sda_meta[1]};
    end
  end

  // bus conditions
  assign scl_rise = !scl_s[1] && scl_s[0];
  assign scl_fall = scl_s[1] && !scl_s[0];
  assign start_c  = scl_s[1] && scl_s[0] && sda_s[1] && !sda_s[0];
  assign stop_c   = scl_s[1] && scl_s[0] && !sda_s[1] && sda_s[0];
  assign upper3   = ptr[7] && (page == cdm_pkg::PAGE_COND);

  // read data multiplexer
  always_comb begin
    rd_byte = 8'h00;
    if (ptr == cdm_pkg::OFS_STATUS) begin
      rd_byte[cdm_pkg::NOT_READY_BIT] = !data_ready;
    end else if (ptr == cdm_pkg::OFS_LOL) begin
      rd_byte = {tx_lol, rx_lol};
    end else if (ptr == cdm_pkg::OFS_CDR_EN) begin
      rd_byte = {tx_recovery_enable_o, rx_recovery_enable_o};
    end else if (ptr == cdm_pkg::OFS_PAGE_SEL) begin
      rd_byte = page;
    end else if (upper3) begin
      case (ptr)
        cdm_pkg::OFS_TX_EQ:          rd_byte = tx_eq_code_o[15:8];
        cdm_pkg::OFS_TX_EQ + 8'h01:  rd_byte = tx_eq_code_o[7:0];
        cdm_pkg::OFS_RX_EMPH:        rd_byte = rx_emph_code_o[15:8];
        cdm_pkg::OFS_RX_EMPH + 8'h01: rd_byte = rx_emph_code_o[7:0];
        cdm_pkg::OFS_RX_AMP:         rd_byte = rx_amp_code_o[15:8];
        cdm_pkg::OFS_RX_AMP + 8'h01: rd_byte = rx_amp_code_o[7:0];
        default:                     rd_byte = 8'h00;
      endcase
    end
  end

  // byte load for transmit happens on the falling clock after an acknowledge
  assign load_rd   = scl_fall && ((state == cdm_pkg::CDM_ACK_AD && rw) ||
                                  (state == cdm_pkg::CDM_ACK_RD && !shreg[0]));
  assign wr_en     = scl_fall && state == cdm_pkg::CDM_WRITE && bit_cnt == 4'h8 && !first;
  assign clr_lol   = load_rd && ptr == cdm_pkg::OFS_LOL;
  assign clr_ready = load_rd && ptr == cdm_pkg::OFS_STATUS;

  // serial slave sequencer
  always_ff @(posedge sys_clk_i) begin
    if (rst) begin
      state    <= cdm_pkg::CDM_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      rw       <= 1'b0;
      first    <= 1'b0;
      ptr      <= 8'h00;
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
    end else if (start_c) begin
      state    <= cdm_pkg::CDM_ADDR;
      bit_cnt  <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (stop_c) begin
      state    <= cdm_pkg::CDM_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      case (state)
        cdm_pkg::CDM_IDLE: begin
          sda_oe_o <= 1'b0;
        end
        cdm_pkg::CDM_ADDR: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], scl_s[0] & sda_s[0]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (shreg[7:1] == DEV_ADDR && bus_ready) begin
              state    <= cdm_pkg::CDM_ACK_AD;
              rw       <= shreg[0];
              sda_oe_o <= 1'b1;
            end else begin
              state <= cdm_pkg::CDM_IDLE;
            end
          end
        end
        cdm_pkg::CDM_ACK_AD: begin
          if (scl_fall) begin
            bit_cnt <= rw ? 4'h1 : 4'h0;
            first   <= 1'b1;
            state   <= rw ? cdm_pkg::CDM_READ : cdm_pkg::CDM_WRITE;
            shreg   <= rd_byte;
            sda_oe_o <= rw && !rd_byte[7];
            if (rw) begin
              ptr <= ptr + 8'h01;
            end
          end
        end
        cdm_pkg::CDM_WRITE: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s[0]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            state    <= cdm_pkg::CDM_ACK_WR;
            sda_oe_o <= 1'b1;
            first    <= 1'b0;
            ptr      <= first ? shreg : ptr + 8'h01;
          end
        end
        cdm_pkg::CDM_ACK_WR: begin
          if (scl_fall) begin
            state    <= cdm_pkg::CDM_WRITE;
            bit_cnt  <= 4'h0;
            sda_oe_o <= 1'b0;
          end
        end
        cdm_pkg::CDM_READ: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              state    <= cdm_pkg::CDM_ACK_RD;
              sda_oe_o <= 1'b0;
            end else begin
              sda_oe_o <= !shreg[6];
              shreg    <= {shreg[6:0], 1'b0};
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
        end
        cdm_pkg::CDM_ACK_RD: begin
          if (scl_rise) begin
            shreg[0] <= sda_s[0];
          end else if (scl_fall) begin
            if (!shreg[0]) begin
              state    <= cdm_pkg::CDM_READ;
              bit_cnt  <= 4'h1;
              shreg    <= rd_byte;
              sda_oe_o <= !rd_byte[7];
              ptr      <= ptr + 8'h01;
            end else begin
              state <= cdm_pkg::CDM_IDLE;
            end
          end
        end
        default: begin
          state    <= cdm_pkg::CDM_IDLE;
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // latched loss-of-lock flags, one per lane and direction; set beats clear
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_ff @(posedge sys_clk_i) begin
      if (rst) begin
        tx_lol[i] <= 1'b0;
        rx_lol[i] <= 1'b0;
      end else begin
        tx_lol[i] <= tx_ll_sync[i] || (tx_lol[i] && !clr_lol);
        rx_lol[i] <= rx_ll_sync[i] || (rx_lol[i] && !clr_lol);
      end
    end
  end

  // recovery enables and page select
  always_ff @(posedge sys_clk_i) begin
    if (rst) begin
      tx_recovery_enable_o <= cdm_pkg::RST_CDR_EN[7:4];
      rx_recovery_enable_o <= cdm_pkg::RST_CDR_EN[3:0];
      page                 <= cdm_pkg::RST_PAGE;
    end else if (wr_en && ptr == cdm_pkg::OFS_CDR_EN) begin
      tx_recovery_enable_o <= shreg[cdm_pkg::TX_FIELD_LSB +: 4];
      rx_recovery_enable_o <= shreg[cdm_pkg::RX_FIELD_LSB +: 4];
    end else if (wr_en && ptr == cdm_pkg::OFS_PAGE_SEL) begin
      page <= shreg;
    end
  end

  // conditioning code fields; a reserved code leaves its nibble unchanged
  for (genvar n = 0; n < LANES; n++) begin : g_nib
    localparam logic [7:0] BOFS = 8'(1 - n / 2); // lanes 3 and 4 in the first byte
    always_ff @(posedge sys_clk_i) begin
      if (rst) begin
        tx_eq_code_o[4*n +: 4]   <= cdm_pkg::RST_CODES[4*(n%4) +: 4];
        rx_emph_code_o[4*n +: 4] <= cdm_pkg::RST_CODES[4*(n%4) +: 4];
        rx_amp_code_o[4*n +: 4]  <= cdm_pkg::RST_CODES[4*(n%4) +: 4];
      end else if (wr_en && upper3) begin
        if (n < 4 && ptr == cdm_pkg::OFS_TX_EQ + BOFS &&
            shreg[4*(n%2) +: 4] <= cdm_pkg::EQ_CODE_MAX) begin
          tx_eq_code_o[4*(n%4) +: 4] <= shreg[4*(n%2) +: 4];
        end
        if (n < 4 && ptr == cdm_pkg::OFS_RX_EMPH + BOFS &&
            shreg[4*(n%2) +: 4] <= cdm_pkg::EMPH_CODE_MAX) begin
          rx_emph_code_o[4*(n%4) +: 4] <= shreg[4*(n%2) +: 4];
        end
        if (n < 4 && ptr == cdm_pkg::OFS_RX_AMP + BOFS &&
            shreg[4*(n%2) +: 4] <= cdm_pkg::AMP_CODE_MAX) begin
          rx_amp_code_o[4*(n%4) +: 4] <= shreg[4*(n%2) +: 4];
        end
      end
    end
  end

  // ready event: data-not-ready clears once, latched until status is read
  always_ff @(posedge sys_clk_i) begin
    if (rst) begin
      data_ready_q     <= 1'b0;
      ready_evt        <= 1'b0;
      data_not_ready_o <= 1'b1;
    end else begin
      data_ready_q     <= data_ready;
      ready_evt        <= (data_ready && !data_ready_q) || (ready_evt && !clr_ready);
      data_not_ready_o <= !data_ready;
    end
  end

  // interrupt output low while any latched source stands
  always_ff @(posedge sys_clk_i) begin
    if (rst) begin
      interrupt_out_active_low_o <= 1'b1;
    end else begin
      interrupt_out_active_low_o <= !(ready_evt || (|tx_lol) || (|rx_lol));
    end
  end

endmodule

`default_nettype wire

// file: verif/cdm_mgmt_properties.sv
// checker of the management block outputs against reset, code and timing limits
`timescale 1ns/1ps
`default_nettype none

module cdm_mgmt_properties #(
  parameter int PULSE_CYCLES  = 500,
  parameter int SERIAL_CYCLES = 1000,
  parameter int INIT_CYCLES   = 2000
) (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        reset_pin_active_low_i,
  input wire logic        sda_oe_o,
  input wire logic [3:0]  tx_lock_lost_i,
  input wire logic [3:0]  tx_recovery_enable_o,
  input wire logic [3:0]  rx_recovery_enable_o,
  input wire logic [15:0] tx_eq_code_o,
  input wire logic [15:0] rx_emph_code_o,
  input wire logic [15:0] rx_amp_code_o,
  input wire logic        data_not_ready_o,
  input wire logic        interrupt_out_active_low_o
);
  int unsigned since_rst;
  int unsigned busy_cnt;
  int unsigned pin_lo;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // saturating counters: since reset, not-ready time, pin low time
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      since_rst <= 0;
    end else if (since_rst < SERIAL_CYCLES + 4) begin
      since_rst <= since_rst + 1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !reset_pin_active_low_i || !data_not_ready_o) begin
      busy_cnt <= 0;
    end else if (busy_cnt < INIT_CYCLES + 16) begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_pin_active_low_i) begin
      pin_lo <= 0;
    end else if (pin_lo < PULSE_CYCLES + 16) begin
      pin_lo <= pin_lo + 1;
    end
  end

  property p_reset_values;
    $rose(reset_n_i) |-> tx_recovery_enable_o == 4'hf && rx_recovery_enable_o == 4'hf && data_not_ready_o;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
  property p_amp;
    rx_amp_code_o[3:0] <= 4'h3 && rx_amp_code_o[7:4] <= 4'h3 && rx_amp_code_o[11:8] <= 4'h3 && rx_amp_code_o[15:12] <= 4'h3;
  endproperty
  a_amp: assert property (p_amp) else $error("reserved amplitude code");
  property p_eq;
    tx_eq_code_o[3:0] <= 4'ha && tx_eq_code_o[7:4] <= 4'ha && tx_eq_code_o[11:8] <= 4'ha && tx_eq_code_o[15:12] <= 4'ha;
  endproperty
  a_eq: assert property (p_eq) else $error("reserved equalization code");
  property p_emph;
    !rx_emph_code_o[3] && !rx_emph_code_o[7] && !rx_emph_code_o[11] && !rx_emph_code_o[15];
  endproperty
  a_emph: assert property (p_emph) else $error("reserved emphasis code");
  property p_init_time;
    busy_cnt <= INIT_CYCLES + 10;
  endproperty
  a_init_time: assert property (p_init_time) else $error("init too long");
  property p_pin_reset;
    pin_lo == PULSE_CYCLES + 8 |-> tx_recovery_enable_o == 4'hf && rx_recovery_enable_o == 4'hf && data_not_ready_o;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not taken");
  property p_bus_ready;
    sda_oe_o |-> since_rst >= SERIAL_CYCLES;
  endproperty
  a_bus_ready: assert property (p_bus_ready) else $error("bus answered early");
  property p_ready_irq;
    $fell(data_not_ready_o) |-> ##[0:2] !interrupt_out_active_low_o;
  endproperty
  a_ready_irq: assert property (p_ready_irq) else $error("no ready interrupt");
  property p_flag_irq;
    (tx_lock_lost_i != 4'h0) [*4] |-> ##[0:2] !interrupt_out_active_low_o;
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("no lock loss interrupt");
endmodule

bind cdm_mgmt cdm_mgmt_properties #(
  .PULSE_CYCLES(PULSE_CYCLES), .SERIAL_CYCLES(SERIAL_CYCLES), .INIT_CYCLES(INIT_CYCLES)
) u_props (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reset_pin_active_low_i(reset_pin_active_low_i),
  .sda_oe_o(sda_oe_o), .tx_lock_lost_i(tx_lock_lost_i), .tx_recovery_enable_o(tx_recovery_enable_o),
  .rx_recovery_enable_o(rx_recovery_enable_o), .tx_eq_code_o(tx_eq_code_o), .rx_emph_code_o(rx_emph_code_o),
  .rx_amp_code_o(rx_amp_code_o), .data_not_ready_o(data_not_ready_o),
  .interrupt_out_active_low_o(interrupt_out_active_low_o)
);

`default_nettype wire

// file: verif/cdm_host.sv
// host controller model: 2-wire bus master and reset pin driver
`timescale 1ns/1ps
`default_nettype none

module cdm_host #(
  parameter logic [6:0] ADDR = cdm_pkg::DEF_DEV_ADDR,
  parameter int         HALF = 8
) (
  input  wire logic sys_clk_i,
  input  wire logic sda_line_i,
  output var logic  scl_o,
  output var logic  sda_o,
  output var logic  pin_n_o
);
  // bus idle, pin released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    pin_n_o = 1'b1;
  end

  task automatic hold();
    repeat (HALF) @(posedge sys_clk_i);
  endtask
  // one bit: data moves only while the clock line is low, sampled at end of high phase
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(posedge sys_clk_i);
    sda_o <= b;
    hold();
    scl_o <= 1'b1;
    hold();
    r = sda_line_i;
    scl_o <= 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    repeat (2) @(posedge sys_clk_i);
    sda_o <= 1'b1;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(posedge sys_clk_i);
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b1;
    hold();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
  // write one or two bytes from a pointer
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1, input bit two, output logic ok);
    logic a0, a1, a2, a3;
    a3 = 1'b1;
    start();
    send({ADDR, 1'b0}, a0);
    send(ptr, a1);
    send(d0, a2);
    if (two) send(d1, a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask
  // set pointer, repeated start, read one byte and end with no ack
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    send({ADDR, 1'b0}, a0);
    send(ptr, a1);
    start();
    send({ADDR, 1'b1}, a2);
    recv(1'b1, d);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // reset request: pin held low for the given cycles
  task automatic pin_pulse(input int cycles);
    pin_n_o <= 1'b0;
    repeat (cycles) @(posedge sys_clk_i);
    pin_n_o <= 1'b1;
  endtask
endmodule

`default_nettype wire

// file: verif/test_cdm_mgmt.sv
// testbench of the management block driven through the host model
`timescale 1ns/1ps
`default_nettype none

module test_cdm_mgmt;
  localparam int INIT = 2000;
  localparam int SER  = 1000;
  localparam int PULSE = 500;
  localparam logic [7:0] OFS [3] = '{cdm_pkg::OFS_TX_EQ, cdm_pkg::OFS_RX_EMPH, cdm_pkg::OFS_RX_AMP};
  localparam logic [3:0] MX [3]  = '{cdm_pkg::EQ_CODE_MAX, cdm_pkg::EMPH_CODE_MAX, cdm_pkg::AMP_CODE_MAX};

  logic        sys_clk_i = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl, host_sda, pin_n, dev_sda, sda_oe, dnr, int_n;
  logic [3:0]  tx_ll = 4'h0;
  logic [3:0]  rx_ll = 4'h0;
  logic [3:0]  tx_en, rx_en;
  logic [15:0] eq, emph, amp;
  wire         sda_line;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // open-drain data line with pull-up
  assign sda_line = host_sda & !(sda_oe && !dev_sda);
  always #2 sys_clk_i = ~sys_clk_i;

  cdm_mgmt #(.LANES(4), .PULSE_CYCLES(PULSE), .SERIAL_CYCLES(SER), .INIT_CYCLES(INIT)) DUT (
    .sys_clk_i(sys_clk_i), .reset_n_i(rst_n), .reset_pin_active_low_i(pin_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(dev_sda), .sda_oe_o(sda_oe), .tx_lock_lost_i(tx_ll), .rx_lock_lost_i(rx_ll),
    .tx_recovery_enable_o(tx_en), .rx_recovery_enable_o(rx_en), .tx_eq_code_o(eq), .rx_emph_code_o(emph),
    .rx_amp_code_o(amp), .data_not_ready_o(dnr), .interrupt_out_active_low_o(int_n)
  );
  cdm_host u_host (
    .sys_clk_i(sys_clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(host_sda), .pin_n_o(pin_n)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // a nibble above the legal maximum leaves the stored one in place
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [3:0] mx);
    logic [15:0] r;
    for (int k = 0; k < 4; k++) r[4*k +: 4] = (nw[4*k +: 4] <= mx) ? nw[4*k +: 4] : old[4*k +: 4];
    return r;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_ready();
    for (int i = 0; i < INIT + 40 && dnr !== 1'b0; i++) @(posedge sys_clk_i);
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles > 100000) begin
      n_errors++;
      $display("BAD %0t run too long", $time);
      end_sim();
    end
  end

  // main sequence
  initial begin
    logic [7:0]  st, d, rb;
    logic        ok;
    logic [15:0] fld [3];
    logic [15:0] nw;
    st = 8'h52;
    fld = '{16'h0, 16'h0, 16'h0};
    repeat (6) @(posedge sys_clk_i);
    rst_n <= 1'b1;
    @(posedge sys_clk_i);
    chk({dnr, tx_en, rx_en}, 9'h1ff, "reset state");
    u_host.rd(cdm_pkg::OFS_CDR_EN, d, ok);
    chk(ok, 1'b0, "answer before bus ready");
    wait_ready();
    chk({dnr, int_n}, 2'b00, "ready with interrupt");
    u_host.rd(cdm_pkg::OFS_STATUS, d, ok);
    chk({ok, d[0]}, 2'b10, "status not-ready bit");
    // enable patterns: all off, all on, then random
    for (int i = 0; i < 6; i++) begin
      st = lfsr(st);
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : st;
      u_host.wr(cdm_pkg::OFS_CDR_EN, d, 8'h00, 1'b0, ok);
      chk({tx_en, rx_en}, d, "enable outputs");
      u_host.rd(cdm_pkg::OFS_CDR_EN, rb, ok);
      chk({ok, rb}, {1'b1, d}, "enable readback");
    end
    u_host.wr(8'h63, ~d, 8'h00, 1'b0, ok);
    chk({tx_en, rx_en}, d, "unmapped write");
    // lock loss pulses, gone again before the read
    st = lfsr(st);
    tx_ll <= st[7:4] | 4'h1;
    rx_ll <= st[3:0];
    repeat (8) @(posedge sys_clk_i);
    tx_ll <= 4'h0;
    rx_ll <= 4'h0;
    repeat (6) @(posedge sys_clk_i);
    chk(int_n, 1'b0, "flag interrupt");
    u_host.rd(cdm_pkg::OFS_LOL, rb, ok);
    chk(rb, st | 8'h10, "latched flags");
    repeat (10) @(posedge sys_clk_i);
    chk(int_n, 1'b1, "interrupt released");
    u_host.rd(cdm_pkg::OFS_LOL, rb, ok);
    chk(rb, 8'h00, "flags cleared by read");
    // every code into every conditioning field
    u_host.wr(cdm_pkg::OFS_PAGE_SEL, cdm_pkg::PAGE_COND, 8'h00, 1'b0, ok);
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < 16; c++) begin
        st = lfsr(st);
        nw = {c[3:0], st[3:0], st};
        fld[f] = merge(fld[f], nw, MX[f]);
        u_host.wr(OFS[f], nw[15:8], nw[7:0], 1'b1, ok);
        chk((f == 0) ? eq : (f == 1) ? emph : amp, fld[f], "code outputs");
        if (c[1:0] == 2'b11) begin
          u_host.rd(OFS[f], rb, ok);
          chk(rb, fld[f][15:8], "code readback");
        end
      end
    end
    // short pin pulse ignored, long one resets
    u_host.pin_pulse(100);
    repeat (10) @(posedge sys_clk_i);
    chk({dnr, tx_en, rx_en}, {1'b0, d}, "short pin pulse");
    u_host.pin_pulse(PULSE + 20);
    chk({dnr, tx_en, rx_en}, 9'h1ff, "pin reset");
    chk(amp, 16'h0000, "pin reset codes");
    wait_ready();
    chk(dnr, 1'b0, "ready after pin reset");
    end_sim();
  end
endmodule

`default_nettype wire
